/* File: core/sbg_map.svh */
`ifndef SBG_MAP_SVH
`define SBG_MAP_SVH

// port offsets inside the sixteen-port block
`define SBG_OFS_ROM_OFF 4'he
`define SBG_OFS_SWITCH 4'hf

// rom window pages
`define SBG_ROM_PAGE_EXT 8'hff
`define SBG_ROM_PAGE 4'hf

// reset values
`define SBG_SOFT_OFF_RST 1'b0
`define SBG_DATA_RST 8'h00
`define SBG_IDX_RST 2'h0

// acknowledge sequence lengths in bytes
`define SBG_INTA_LEN_80 2'h3
`define SBG_INTA_LEN_86 2'h2
`define SBG_INTA_LEN_NONE 2'h0

// wait state timing
`define SBG_CLK_NS 10
`define SBG_WAIT_NS 125
`define SBG_WAIT_CYCLES ((`SBG_WAIT_NS + `SBG_CLK_NS - 1) / `SBG_CLK_NS)

// synchroniser width: address, strobes, switches, jumpers, handshakes
`define SBG_SYNC_W 53

`endif

/* File: core/sbg_pkg.sv */
`default_nettype none
package sbg_pkg;

   typedef enum logic [1:0] {
      SBG_CPU_NONE = 2'b00,
      SBG_CPU_80 = 2'b01,
      SBG_CPU_86 = 2'b10
   } sbg_cpu_type;

   typedef enum logic [0:0] {
      SBG_WS_IDLE = 1'b0,
      SBG_WS_HOLD = 1'b1
   } sbg_ws_state_type;

endpackage
`default_nettype wire

/* File: core/sbg_sync.sv */
`timescale 1ns/1ns
`default_nettype none
module sbg_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   import sbg_pkg::*;

   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage2_reg;

   if (W < 1) begin : g_chk
      $error("sbg_sync width must be at least one");
   end

   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= d;
         stage2_reg <= stage1_reg;
      end
   end

   assign q = stage2_reg;
endmodule
`default_nettype wire

/* File: core/sbg_top.sv */
// Function
// - select on i/o only when port bits 7:4 equal the port_block_origin switches
// - port_block_origin switch positions one to four map to A7..A4, closed is one
// - socket switch closed enables rom, open kills every rom response
// - extended: compare 20 bits at ff000/ff800, else 16 bits f000/f800
// - master wait switch open: no wait states at all
// - master closed, qualify open: one wait state per answered cycle
// - both closed: wait state only while bus shows high speed
// - input from offset 15 returns option switches, position one in bit 0
// - serial transmit passes only while terminal-ready is asserted
// - terminal-ready open: jumper decides transmitter enabled or held off
// - parallel data drives always, or floats while acknowledge is low
// - small rom: window jumper high picks f800 page, low picks f000
// - large rom: whole f000..ffff page, window jumper ignored
// - rom-type jumper picks small or large rom, address lines and size
// - cycle jumper picks three-byte or two-byte acknowledge sequence
// - cycle jumper open: never take over bus during acknowledge
// - overlay jumper set: pull phantom while rom selected, else never
// - rom disable answers input and output at offset 14
`timescale 1ns/1ns
`default_nettype none
`include "sbg_map.svh"
module sbg_top #(
   parameter int WAIT_CYC = `SBG_WAIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [19:0] bus_addr,
   input wire logic bus_cyc,
   input wire logic bus_mem_rd,
   input wire logic bus_io_rd,
   input wire logic bus_io_wr,
   input wire logic bus_speed_hi,
   input wire logic bus_inta,
   input wire logic [7:0] port_block_origin_and_rom_config_switch,
   input wire logic [7:0] option_switch_bank,
   input wire logic jmp_dtr_plus,
   input wire logic jmp_out_plus,
   input wire logic jmp_addr_hi,
   input wire logic jmp_rom32,
   input wire sbg_pkg::sbg_cpu_type jmp_cpu,
   input wire logic jmp_phantom_plus,
   input wire logic dtr_level,
   input wire logic dtr_open,
   input wire logic ack_level,
   input wire logic ack_open,
   input wire logic uart_txd,
   output logic io_sel,
   output logic [3:0] io_func,
   output logic rom_sel,
   output logic [11:0] rom_addr,
   output logic phantom_n_o,
   output logic phantom_n_oe,
   output logic rdy_n_o,
   output logic rdy_n_oe,
   output logic [7:0] bus_data_o,
   output logic bus_data_oe,
   output logic serial_txd,
   output logic par_data_oe,
   output logic inta_takeover,
   output logic [1:0] inta_len,
   output logic [1:0] inta_byte_idx
);
   import sbg_pkg::*;

   // every pin, strap and jumper except uart_txd passes the two-stage synchroniser;
   // the address is settled before the cycle strobe, so the
   // strobe's own delay covers skew between the bits
   wire logic [`SBG_SYNC_W-1:0] pin_raw;
   wire logic [`SBG_SYNC_W-1:0] pin_s;

   assign pin_raw = {bus_addr, bus_cyc, bus_mem_rd, bus_io_rd, bus_io_wr,
      bus_speed_hi, bus_inta, port_block_origin_and_rom_config_switch,
      option_switch_bank, jmp_dtr_plus, jmp_out_plus, jmp_addr_hi,
      jmp_rom32, jmp_cpu, jmp_phantom_plus, dtr_level, dtr_open,
      ack_level, ack_open};

   sbg_sync #(
      .W(`SBG_SYNC_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .d(pin_raw),
      .q(pin_s)
   );

   wire logic [19:0] a_s;
   wire logic cyc_s, mem_rd_s, io_rd_s, io_wr_s, speed_s, inta_s;
   wire logic [7:0] sw1_s, sw2_s;
   wire logic dtr_j_s, out_j_s, addr_hi_s, rom32_s, phantom_j_s;
   wire logic [1:0] cpu_s;
   wire logic dtr_lvl_s, dtr_open_s, ack_lvl_s, ack_open_s;

   assign {a_s, cyc_s, mem_rd_s, io_rd_s, io_wr_s, speed_s, inta_s,
      sw1_s, sw2_s, dtr_j_s, out_j_s, addr_hi_s, rom32_s, cpu_s,
      phantom_j_s, dtr_lvl_s, dtr_open_s, ack_lvl_s, ack_open_s} = pin_s;

   // cycle and acknowledge edges, taken from the synchronised copies
   logic cyc_prev_reg;
   logic inta_prev_reg;
   wire logic cyc_start;
   wire logic inta_rise;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cyc_prev_reg <= 1'b0;
         inta_prev_reg <= 1'b0;
      end else begin
         cyc_prev_reg <= cyc_s;
         inta_prev_reg <= inta_s;
      end
   end

   assign cyc_start = cyc_s && !cyc_prev_reg;
   assign inta_rise = inta_s && !inta_prev_reg;

   // switch bank one: positions 1..4 port_block_origin, 5 socket, 6 extended,
   // 7 speed qualify, 8 wait master; closed reads as one
   wire logic [3:0] port_block_origin_sw;
   wire logic rom_socket_on, ext_addr, sw_qualify, sw_master;

   assign port_block_origin_sw = {sw1_s[0], sw1_s[1], sw1_s[2], sw1_s[3]};
   assign rom_socket_on = sw1_s[4];
   assign ext_addr = sw1_s[5];
   assign sw_qualify = sw1_s[6];
   assign sw_master = sw1_s[7];

   // i/o block decode
   wire logic io_cyc, io_hit, hit_rom_off, hit_switch;

   assign io_cyc = cyc_s && (io_rd_s || io_wr_s);
   assign io_hit = io_cyc && (a_s[7:4] == port_block_origin_sw);
   assign hit_rom_off = io_hit && (a_s[3:0] == `SBG_OFS_ROM_OFF);
   assign hit_switch = io_hit && (a_s[3:0] == `SBG_OFS_SWITCH);
   assign io_sel = io_hit;
   assign io_func = io_hit ? a_s[3:0] : 4'h0;

   // rom software disable; only a reset brings the rom back
   logic soft_off_reg, soft_off_next;

   assign soft_off_next = soft_off_reg || (cyc_start && hit_rom_off);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         soft_off_reg <= `SBG_SOFT_OFF_RST;
      end else begin
         soft_off_reg <= soft_off_next;
      end
   end

   // rom window decode
   wire logic page_ok, half_ok, rom_window;

   assign page_ok = ext_addr ? (a_s[19:12] == `SBG_ROM_PAGE_EXT)
      : (a_s[15:12] == `SBG_ROM_PAGE);
   // the large part takes the whole page, so the half bit is free
   assign half_ok = rom32_s || (a_s[11] == addr_hi_s);
   assign rom_window = page_ok && half_ok;
   assign rom_sel = cyc_s && mem_rd_s && rom_window
      && rom_socket_on && !soft_off_reg;

   // small part sees eleven lines; line 11 held low to the socket
   logic [11:0] rom_addr_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rom_addr_reg <= 12'h000;
      end else if (rom32_s) begin
         rom_addr_reg <= a_s[11:0];
      end else begin
         rom_addr_reg <= {1'b0, a_s[10:0]};
      end
   end

   assign rom_addr = rom_addr_reg;

   // overlay: open-drain pull, only while rom selected
   assign phantom_n_o = 1'b0;
   assign phantom_n_oe = phantom_j_s && rom_sel;

   // wait state generator; drives ready low while holding
   wire logic wait_busy;
   wire logic answered;

   assign answered = io_hit || rom_sel;

   sbg_wait_gen #(
      .WAIT_CYC(WAIT_CYC)
   ) u_wait (
      .sys_clk(sys_clk),
      .rst(rst),
      .cyc_start(cyc_start),
      .answered(answered),
      .sw_master(sw_master),
      .sw_qualify(sw_qualify),
      .speed_hi(speed_s),
      .wait_busy(wait_busy)
   );

   assign rdy_n_o = 1'b0;
   assign rdy_n_oe = wait_busy;

   // readback of option switches and disable status
   logic [7:0] data_reg, data_next;
   logic data_oe_reg;
   wire logic rd_switch, rd_rom_off;

   assign rd_switch = hit_switch && io_rd_s;
   assign rd_rom_off = hit_rom_off && io_rd_s;
   assign data_next = rd_switch ? sw2_s
      : rd_rom_off ? {7'h00, soft_off_reg} : `SBG_DATA_RST;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         data_reg <= `SBG_DATA_RST;
         data_oe_reg <= 1'b0;
      end else begin
         data_reg <= data_next;
         data_oe_reg <= rd_switch || rd_rom_off;
      end
   end

   assign bus_data_o = data_reg;
   assign bus_data_oe = data_oe_reg;

   // serial transmit gate; mark level while held off
   logic txd_reg;
   wire logic tx_enable;

   assign tx_enable = dtr_open_s ? dtr_j_s : dtr_lvl_s;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txd_reg <= 1'b1;
      end else begin
         txd_reg <= tx_enable ? uart_txd : 1'b1;
      end
   end

   assign serial_txd = txd_reg;

   // parallel output drive mode
   logic par_oe_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         par_oe_reg <= 1'b0;
      end else begin
         par_oe_reg <= out_j_s || ack_open_s || ack_lvl_s;
      end
   end

   assign par_data_oe = par_oe_reg;

   // interrupt acknowledge sequencing
   sbg_cpu_type cpu_mode;
   logic [1:0] len_sel;
   logic [1:0] idx_reg, idx_next;
   logic take_reg;

   assign cpu_mode = sbg_cpu_type'(cpu_s);

   always_comb begin
      case (cpu_mode)
         SBG_CPU_80: len_sel = `SBG_INTA_LEN_80;
         SBG_CPU_86: len_sel = `SBG_INTA_LEN_86;
         default: len_sel = `SBG_INTA_LEN_NONE;
      endcase
   end

   always_comb begin
      idx_next = idx_reg;
      if (len_sel == `SBG_INTA_LEN_NONE) begin
         idx_next = `SBG_IDX_RST;
      end else if (inta_rise) begin
         if (idx_reg == 2'(len_sel - 2'h1)) begin
            idx_next = `SBG_IDX_RST;
         end else begin
            idx_next = idx_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         idx_reg <= `SBG_IDX_RST;
         take_reg <= 1'b0;
      end else begin
         idx_reg <= idx_next;
         // unconnected jumper: the cpu supplies status itself
         take_reg <= (len_sel != `SBG_INTA_LEN_NONE)
            && (inta_s || idx_next != `SBG_IDX_RST);
      end
   end

   assign inta_len = len_sel;
   assign inta_byte_idx = idx_reg;
   assign inta_takeover = take_reg;

   a_io_port_block_origin_match: assert property (@(posedge sys_clk) disable iff (rst)
      io_sel |-> io_cyc && a_s[7:4] == {sw1_s[0], sw1_s[1], sw1_s[2],
      sw1_s[3]} && io_func == a_s[3:0])
      else $error("board selected outside its port_block_origin");

   a_port_block_origin_bit_order: assert property (@(posedge sys_clk) disable iff (rst)
      io_cyc && a_s[7] != sw1_s[0] |-> !io_sel)
      else $error("A7 not compared with position one");

   a_rom_socket_off: assert property (@(posedge sys_clk) disable iff (rst)
      !sw1_s[4] |-> !rom_sel && !phantom_n_oe)
      else $error("rom answers with socket switch open");

   a_rom_ext_page: assert property (@(posedge sys_clk) disable iff (rst)
      rom_sel |-> (sw1_s[5] ? a_s[19:12] == 8'hff : a_s[15:12] == 4'hf))
      else $error("rom selected outside its page");

   a_rom_small_half: assert property (@(posedge sys_clk) disable iff (rst)
      rom_sel && !rom32_s |-> a_s[11] == addr_hi_s)
      else $error("small rom in wrong half page");

   a_rom_addr_lines: assert property (@(posedge sys_clk) disable iff (rst)
      !rom32_s && !$past(rom32_s) |-> !rom_addr[11])
      else $error("small rom sees line 11");

   a_rom_mem_only: assert property (@(posedge sys_clk) disable iff (rst)
      rom_sel |-> mem_rd_s && cyc_s && !soft_off_reg)
      else $error("rom selected off a memory read");

   sequence s_off_held;
      soft_off_reg ##1 soft_off_reg;
   endsequence

   a_soft_off_sticky: assert property (@(posedge sys_clk) disable iff (rst)
      cyc_start && hit_rom_off |=> s_off_held)
      else $error("rom disable access not taken");

   a_sense_readback: assert property (@(posedge sys_clk) disable iff (rst)
      rd_switch |=> bus_data_oe && bus_data_o == $past(sw2_s))
      else $error("option switch readback wrong");

   a_phantom_follow: assert property (@(posedge sys_clk) disable iff (rst)
      phantom_n_oe == (rom_sel && phantom_j_s))
      else $error("phantom drive wrong");

   a_tx_gate_held: assert property (@(posedge sys_clk) disable iff (rst)
      !dtr_open_s && !dtr_lvl_s |=> serial_txd)
      else $error("transmit passed without terminal ready");

   a_tx_open_jumper: assert property (@(posedge sys_clk) disable iff (rst)
      dtr_open_s && dtr_j_s |=> serial_txd == $past(uart_txd))
      else $error("open terminal-ready jumper ignored");

   a_par_float_ack: assert property (@(posedge sys_clk) disable iff (rst)
      !out_j_s && !ack_open_s && !ack_lvl_s |=> !par_data_oe)
      else $error("parallel data driven while ack low");

   a_inta_none_free: assert property (@(posedge sys_clk) disable iff (rst)
      cpu_mode == SBG_CPU_NONE && $past(cpu_mode) == SBG_CPU_NONE
      |-> !inta_takeover)
      else $error("bus taken with cycle jumper open");

   a_inta_len_sel: assert property (@(posedge sys_clk) disable iff (rst)
      cpu_mode == SBG_CPU_80 |-> inta_len == 2'h3)
      else $error("acknowledge length not three bytes");
endmodule
`default_nettype wire

/* File: core/sbg_wait_gen.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sbg_map.svh"
module sbg_wait_gen #(
   parameter int WAIT_CYC = `SBG_WAIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cyc_start,
   input wire logic answered,
   input wire logic sw_master,
   input wire logic sw_qualify,
   input wire logic speed_hi,
   output logic wait_busy
);
   import sbg_pkg::*;

   sbg_ws_state_type state_reg, state_next;
   logic [7:0] cnt_reg, cnt_next;
   wire logic need_wait;
   wire logic [7:0] last_cnt;

   if (WAIT_CYC < 1 || WAIT_CYC > 255) begin : g_chk
      $error("WAIT_CYC out of range 1..255");
   end

   assign last_cnt = 8'(WAIT_CYC - 1);
   // master open: never; qualify closed: only at high speed
   assign need_wait = answered && sw_master && (!sw_qualify || speed_hi);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         SBG_WS_IDLE: begin
            cnt_next = 8'h00;
            if (cyc_start && need_wait) begin
               state_next = SBG_WS_HOLD;
            end
         end
         SBG_WS_HOLD: begin
            if (cnt_reg == last_cnt) begin
               state_next = SBG_WS_IDLE;
               cnt_next = 8'h00;
            end else begin
               cnt_next = cnt_reg + 8'h01;
            end
         end
         default: begin
            state_next = SBG_WS_IDLE;
            cnt_next = 8'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= SBG_WS_IDLE;
         cnt_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign wait_busy = (state_reg == SBG_WS_HOLD);

   a_no_wait_master: assert property (@(posedge sys_clk) disable iff (rst)
      cyc_start && !sw_master && !wait_busy |=> !wait_busy)
      else $error("wait inserted with master switch open");

   a_wait_one_len: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(wait_busy) |-> $past(cnt_reg) == last_cnt)
      else $error("wait state length wrong");

   a_wait_start: assert property (@(posedge sys_clk) disable iff (rst)
      cyc_start && !wait_busy && answered && sw_master && !sw_qualify
      |=> wait_busy)
      else $error("answered cycle got no wait state");

   a_wait_speed_gate: assert property (@(posedge sys_clk) disable iff (rst)
      cyc_start && !wait_busy && sw_qualify && !speed_hi |=> !wait_busy)
      else $error("wait inserted at low speed");
endmodule
`default_nettype wire

/* File: tb/sbg_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sbg_host_model (
   input wire logic sys_clk,
   input wire logic io_sel,
   input wire logic [3:0] io_func,
   input wire logic rom_sel,
   input wire logic [11:0] rom_addr,
   input wire logic phantom_n_oe,
   input wire logic rdy_n_oe,
   input wire logic [7:0] bus_data_o,
   input wire logic bus_data_oe,
   input wire logic inta_takeover,
   output logic [19:0] bus_addr,
   output logic bus_cyc,
   output logic bus_mem_rd,
   output logic bus_io_rd,
   output logic bus_io_wr,
   output logic bus_inta
);
   initial begin
      bus_addr = 20'h00000;
      {bus_cyc, bus_mem_rd, bus_io_rd, bus_io_wr, bus_inta} = 5'h00;
   end
   // kind 0 memory read, 1 i/o input, 2 i/o output
   task automatic cycle(input logic [1:0] kind, input logic [19:0] a,
         output logic [27:0] ob, output int w);
      ob = 28'h0000000;
      @(negedge sys_clk);
      bus_addr = a;
      bus_mem_rd = (kind == 2'h0);
      bus_io_rd = (kind == 2'h1);
      bus_io_wr = (kind == 2'h2);
      // status must settle two clocks ahead of the strobe
      repeat (2) @(negedge sys_clk);
      bus_cyc = 1'b1;
      w = 0;
      for (int i = 0; i < 8; i++) begin
         @(negedge sys_clk);
         if (i == 2) begin
            ob = {io_sel, rom_sel, phantom_n_oe, bus_data_oe, io_func,
               bus_data_o, rom_addr};
         end
         // an unknown ready counts as a wait, so it cannot slip through
         if (rdy_n_oe !== 1'b0) begin
            w++;
         end
      end
      {bus_cyc, bus_mem_rd, bus_io_rd, bus_io_wr} = 4'h0;
      // a released bus floats: show the inverse, never the old value
      bus_addr = ~a;
      repeat (3) @(negedge sys_clk);
   endtask
   // the host keeps its own status valid through every ack byte
   task automatic inta_pulse(output logic tk);
      @(negedge sys_clk);
      bus_inta = 1'b1;
      repeat (3) @(negedge sys_clk);
      tk = inta_takeover;
      bus_inta = 1'b0;
      repeat (4) @(negedge sys_clk);
   endtask
endmodule
`default_nettype wire

/* File: tb/sbg_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module sbg_tb_top;
   import sbg_pkg::*;
   localparam int WC = 2;
   logic sys_clk, rst, bus_speed_hi, jmp_dtr_plus, jmp_out_plus, jmp_addr_hi;
   logic jmp_rom32, jmp_phantom_plus, dtr_level, dtr_open, ack_level;
   logic ack_open, uart_txd, io_sel, rom_sel, phantom_n_o, phantom_n_oe;
   logic rdy_n_o, rdy_n_oe, bus_data_oe, serial_txd, par_data_oe, tk;
   logic inta_takeover, bus_cyc, bus_inta, bus_mem_rd, bus_io_rd, bus_io_wr;
   logic [19:0] bus_addr;
   logic [7:0] port_block_origin_and_rom_config_switch, option_switch_bank, bus_data_o;
   logic [3:0] io_func;
   logic [11:0] rom_addr;
   logic [1:0] inta_len, inta_byte_idx;
   logic [27:0] ob;
   sbg_cpu_type jmp_cpu;
   int err_total = 0;
   int checked = 0;
   int w, ln;
   logic [8:0] io_t [5] = '{9'h1a5, 9'h055, 9'h025, 9'h0e5, 9'h1a5};
   logic [3:0] wt [4] = '{4'b0110, 4'b1001, 4'b1100, 4'b1111};
   logic [3:0] st [4] = '{4'b1001, 4'b0010, 4'b0111, 4'b0100};
   logic [3:0] pt [4] = '{4'b1001, 4'b0000, 4'b0101, 4'b0011};
   // ext, large rom, high half, expected hit, address
   logic [23:0] rt [10] = '{24'h30f800, 24'h20f7ff, 24'h33f9ab, 24'hbff800,
      24'ha0f800, 24'h9ff000, 24'h8ff800, 24'h70f000, 24'hfffa23, 24'hcefa23};

   sbg_top #(.WAIT_CYC(WC)) sbg_top_i (.sys_clk, .rst, .bus_addr, .bus_cyc,
      .bus_mem_rd, .bus_io_rd, .bus_io_wr, .bus_speed_hi, .bus_inta,
      .port_block_origin_and_rom_config_switch, .option_switch_bank, .jmp_dtr_plus,
      .jmp_out_plus, .jmp_addr_hi, .jmp_rom32, .jmp_cpu, .jmp_phantom_plus,
      .dtr_level, .dtr_open, .ack_level, .ack_open, .uart_txd, .io_sel,
      .io_func, .rom_sel, .rom_addr, .phantom_n_o, .phantom_n_oe, .rdy_n_o,
      .rdy_n_oe, .bus_data_o, .bus_data_oe, .serial_txd, .par_data_oe,
      .inta_takeover, .inta_len, .inta_byte_idx);

   sbg_host_model sbg_host_model_i (.sys_clk, .io_sel, .io_func, .rom_sel,
      .rom_addr, .phantom_n_oe, .rdy_n_oe, .bus_data_o, .bus_data_oe,
      .inta_takeover, .bus_addr, .bus_cyc, .bus_mem_rd, .bus_io_rd,
      .bus_io_wr, .bus_inta);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string nm, input logic [11:0] e,
         input logic [11:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_n(input string nm, input int e, input int g);
      checked++;
      if (g != e) begin
         err_total++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic note(input string s);
      $display("test %s done, mismatches so far %0d", s, err_total);
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // reset also flushes the pin synchronisers, so hold it well past two
   task automatic do_reset;
      rst = 1'b1;
      repeat (4) @(negedge sys_clk);
      rst = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic cyc(input logic [1:0] k, input logic [19:0] a);
      sbg_host_model_i.cycle(k, a, ob, w);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      $display("[ERR] watchdog expired");
      test_done;
   end

   initial begin
      rst = 1'b1;
      {bus_speed_hi, jmp_dtr_plus, jmp_out_plus, jmp_addr_hi} = 4'h0;
      {jmp_rom32, jmp_phantom_plus, dtr_level, dtr_open} = 4'h0;
      {ack_level, ack_open, uart_txd} = 3'h1;
      port_block_origin_and_rom_config_switch = 8'h15;
      option_switch_bank = 8'h96;
      jmp_cpu = SBG_CPU_86;
      do_reset;
      for (int i = 0; i < 5; i++) begin
         cyc(2'h1, {12'h000, io_t[i][7:0]});
         chk("io_sel", 12'(io_t[i][8]), 12'(ob[27]));
         if (io_t[i][8]) begin
            chk("io_func", 12'h005, 12'(ob[23:20]));
            chk("data_oe", 12'h000, 12'(ob[24]));
         end
      end
      note("io decode");
      for (int i = 0; i < 4; i++) begin
         port_block_origin_and_rom_config_switch = {wt[i][3:2], 2'b01, 4'h5};
         bus_speed_hi = wt[i][1];
         cyc(2'h1, 20'h000af);
         chk_n("wait_cycles", wt[i][0] ? WC : 0, w);
         chk("switch_data", 12'(8'h96), 12'(ob[19:12]));
         chk("data_oe", 12'h001, 12'(ob[24]));
      end
      port_block_origin_and_rom_config_switch = 8'h95;
      jmp_addr_hi = 1'b1;
      cyc(2'h0, 20'h0f800);
      chk_n("rom_wait", WC, w);
      chk("rdy_level", 12'h000, 12'(rdy_n_o));
      cyc(2'h1, 20'h00055);
      chk_n("miss_wait", 0, w);
      note("wait states");
      for (int i = 0; i < 10; i++) begin
         port_block_origin_and_rom_config_switch = {2'b00, rt[i][23], 1'b1, 4'h5};
         jmp_rom32 = rt[i][22];
         jmp_addr_hi = rt[i][21];
         jmp_phantom_plus = i[0];
         cyc(2'h0, rt[i][19:0]);
         chk("rom_sel", 12'(rt[i][20]),
            12'(ob[26]));
         chk("phantom", 12'(rt[i][20] & i[0]), 12'(ob[25]));
         if (rt[i][20]) begin
            chk("rom_addr", rt[i][22] ? rt[i][11:0] : {1'b0, rt[i][10:0]},
               ob[11:0]);
         end
      end
      chk("phantom_level", 12'h000, 12'(phantom_n_o));
      cyc(2'h1, 20'h0f800);
      chk("io_not_rom", 12'h000, 12'(ob[26]));
      note("rom window");
      port_block_origin_and_rom_config_switch = 8'h15;
      {jmp_rom32, jmp_addr_hi} = 2'b01;
      cyc(2'h0, 20'h0f800);
      chk("rom_sel", 12'h001, 12'(ob[26]));
      cyc(2'h2, 20'h000ae);
      chk("off_port", 12'h01e, {7'h00, ob[27], ob[23:20]});
      cyc(2'h0, 20'h0f800);
      chk("rom_off", 12'h000, 12'(ob[26]));
      do_reset;
      cyc(2'h1, 20'h000ae);
      chk("off_rd_oe", 12'h001, 12'(ob[24]));
      chk("off_rd_bit", 12'h000, 12'(ob[12]));
      cyc(2'h0, 20'h0f800);
      chk("rom_off_rd", 12'h000, 12'(ob[26]));
      do_reset;
      port_block_origin_and_rom_config_switch = 8'h05;
      cyc(2'h0, 20'h0f800);
      chk("socket_off", 12'h000, 12'(ob[26]));
      note("rom disable");
      uart_txd = 1'b0;
      for (int i = 0; i < 4; i++) begin
         {dtr_level, dtr_open, jmp_dtr_plus} = st[i][3:1];
         repeat (5) @(negedge sys_clk);
         chk("serial_txd", 12'(!st[i][0]), 12'(serial_txd));
      end
      for (int i = 0; i < 4; i++) begin
         {jmp_out_plus, ack_level, ack_open} = pt[i][3:1];
         repeat (5) @(negedge sys_clk);
         chk("par_data_oe", 12'(pt[i][0]), 12'(par_data_oe));
      end
      note("serial and parallel");
      for (int m = 0; m < 3; m++) begin
         jmp_cpu = m == 0 ? SBG_CPU_80 : m == 1 ? SBG_CPU_86 : SBG_CPU_NONE;
         do_reset;
         ln = m == 2 ? 0 : 3 - m;
         chk("inta_len", 12'(ln), 12'(inta_len));
         for (int n = 0; n < 4; n++) begin
            sbg_host_model_i.inta_pulse(tk);
            chk("takeover", 12'(ln != 0), 12'(tk));
            chk("byte_idx", 12'(ln == 0 ? 0 : (n + 1) % ln),
               12'(inta_byte_idx));
         end
      end
      note("acknowledge");
      test_done;
   end
endmodule
`default_nettype wire
